/* File: hdl/rmx_regs.sv */
/*
 * Right output mixer control register bank with an AXI4-Lite slave.
 * Assumes a single 100 MHz clock, synchronous active-high reset and a master
 * that keeps at most one read and one write outstanding.
 */
`timescale 1ns/1ps

module rmx_regs
    import rmx_pkg::*;
(
    input wire logic clk_i, // Register clock
    input wire logic reset_i, // Synchronous reset
    input wire logic s_axi_awvalid_i, // Write address valid
    output logic s_axi_awready_o, // Write address ready
    input wire logic [31:0] s_axi_awaddr_i, // Write byte address
    input wire logic s_axi_wvalid_i, // Write data valid
    output logic s_axi_wready_o, // Write data ready
    input wire logic [31:0] s_axi_wdata_i, // Write data
    input wire logic [3:0] s_axi_wstrb_i, // Byte strobes
    output logic s_axi_bvalid_o, // Write response valid
    input wire logic s_axi_bready_i, // Write response ready
    output logic [1:0] s_axi_bresp_o, // Write response code
    input wire logic s_axi_arvalid_i, // Read address valid
    output logic s_axi_arready_o, // Read address ready
    input wire logic [31:0] s_axi_araddr_i, // Read byte address
    output logic s_axi_rvalid_o, // Read data valid
    input wire logic s_axi_rready_i, // Read data ready
    output logic [31:0] s_axi_rdata_o, // Read data
    output logic [1:0] s_axi_rresp_o, // Read response code
    output rmx_hp_ctrl_s main_hp_o, // Right main headphone controls
    output rmx_hp_ctrl_s common_hp_o, // Right common headphone controls
    output rmx_route_s route_o [NUM_ROUTE], // Mixer routing and volumes
    output logic main_pend_o, // Main gain not yet applied
    output logic common_pend_o // Common gain not yet applied
);

    // ==========================================================================
    // Address decode helpers
    function automatic logic [6:0] addr_idx(input logic [31:0] a);
        return a[8:2];
    endfunction : addr_idx

    function automatic logic addr_mapped(input logic [31:0] a);
        return (a[31:9] == 23'h000000) && (a[1:0] == 2'h0) &&
            (a[8:2] >= IDX_MAIN_LEVEL) && (a[8:2] <= IDX_LPGA_LLINE);
    endfunction : addr_mapped

    function automatic logic idx_read_only(input logic [6:0] i);
        return (i >= IDX_RSVD_RO_FIRST) && (i <= IDX_RSVD_80);
    endfunction : idx_read_only

    localparam logic [SETTLE_W-1:0] SETTLE_CNT = SETTLE_W'(SETTLE_CYC);

    // ==========================================================================
    // State
    rmx_chan_e wr_st_ff;
    rmx_chan_e rd_st_ff;
    logic aw_held_ff;
    logic w_held_ff;
    logic [31:0] awaddr_ff;
    logic [7:0] wdata_ff;
    logic wstrb_ff;
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    rmx_hp_ctrl_s main_hp_ff;
    rmx_hp_ctrl_s common_hp_ff;
    rmx_route_s route_ff [NUM_ROUTE];
    logic [7:0] rsvd66_ff;
    logic [7:0] rsvd69_ff;
    logic [1:0] pend_ff;
    logic [SETTLE_W-1:0] cnt_ff [2];

    logic nxt_aw_held;
    logic nxt_w_held;
    logic wr_go;
    logic [6:0] widx;
    logic wr_ok;
    logic wr_en;
    logic [1:0] trig;
    logic [7:0] rd_byte;
    logic rd_ok;

    // ==========================================================================
    // Write channel: address and data taken in either order
    always_comb begin
        nxt_aw_held = aw_held_ff | (s_axi_awvalid_i & awready_ff);
        nxt_w_held = w_held_ff | (s_axi_wvalid_i & wready_ff);
        wr_go = (wr_st_ff == RMX_CH_IDLE) && aw_held_ff && w_held_ff;
        widx = addr_idx(awaddr_ff);
        wr_ok = addr_mapped(awaddr_ff) && !idx_read_only(widx);
        wr_en = wr_go && wr_ok && wstrb_ff;
    end

    // Captured address and data
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            awaddr_ff <= 32'h00000000;
            wdata_ff <= 8'h00;
            wstrb_ff <= 1'b0;
        end else begin
            if (s_axi_awvalid_i && awready_ff) begin
                awaddr_ff <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && wready_ff) begin
                wdata_ff <= s_axi_wdata_i[7:0]; // Only the low lane carries data
                wstrb_ff <= s_axi_wstrb_i[0];
            end
        end
    end

    // Write handshake state; readies drop while a response is owed
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wr_st_ff <= RMX_CH_IDLE;
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else begin
            case (wr_st_ff)
                RMX_CH_IDLE: begin
                    if (wr_go) begin
                        wr_st_ff <= RMX_CH_RESP;
                        aw_held_ff <= 1'b0;
                        w_held_ff <= 1'b0;
                        awready_ff <= 1'b0;
                        wready_ff <= 1'b0;
                        bvalid_ff <= 1'b1;
                        bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
                    end else begin
                        aw_held_ff <= nxt_aw_held;
                        w_held_ff <= nxt_w_held;
                        awready_ff <= !nxt_aw_held;
                        wready_ff <= !nxt_w_held;
                    end
                end
                RMX_CH_RESP: begin
                    if (s_axi_bready_i) begin
                        wr_st_ff <= RMX_CH_IDLE;
                        bvalid_ff <= 1'b0;
                        awready_ff <= 1'b1;
                        wready_ff <= 1'b1;
                    end
                end
                default: begin
                    wr_st_ff <= RMX_CH_IDLE;
                    bvalid_ff <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================================
    // Output level registers; reserved level codes are stored as written
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            main_hp_ff <= HP_CTRL_RST;
        end else if (wr_en && widx == IDX_MAIN_LEVEL) begin
            main_hp_ff.level <= wdata_ff[LVL_MSB:LVL_LSB];
            main_hp_ff.unmute <= wdata_ff[MUTE_BIT];
            main_hp_ff.pd_hiz <= wdata_ff[PDHIZ_BIT];
            main_hp_ff.power_up <= wdata_ff[PWR_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            common_hp_ff <= HP_CTRL_RST;
        end else if (wr_en && widx == IDX_COMMON_LEVEL) begin
            common_hp_ff.level <= wdata_ff[LVL_MSB:LVL_LSB];
            common_hp_ff.unmute <= wdata_ff[MUTE_BIT];
            common_hp_ff.pd_hiz <= wdata_ff[PDHIZ_BIT];
            common_hp_ff.power_up <= wdata_ff[PWR_BIT];
        end
    end

    // Reserved words that still hold what was written
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rsvd66_ff <= RSVD_RW_RST;
            rsvd69_ff <= RSVD_RW_RST;
        end else begin
            if (wr_en && widx == IDX_RSVD_66) begin
                rsvd66_ff <= wdata_ff;
            end
            if (wr_en && widx == IDX_RSVD_69) begin
                rsvd69_ff <= wdata_ff;
            end
        end
    end

    // ==========================================================================
    // Routing registers: enable in D7, volume code in D6-D0
    for (genvar g = 0; g < NUM_ROUTE; g++) begin : g_route
        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                route_ff[g] <= rmx_route_s'(ROUTE_RST);
            end else if (wr_en && widx == ROUTE_IDX[g]) begin
                route_ff[g] <= rmx_route_s'(wdata_ff);
            end
        end
        assign route_o[g] = route_ff[g];

        // Own clock here: this check sits above the module's default clocking
        chk_route_write: assert property (@(posedge clk_i) disable iff (reset_i)
            wr_en && widx == ROUTE_IDX[g] |=> route_ff[g] == rmx_route_s'($past(wdata_ff)))
            else $error("routing register did not take written value");
    end

    // ==========================================================================
    // Gain settle tracking; a new write restarts the wait, so set wins
    always_comb begin
        trig[0] = wr_en && (widx == IDX_MAIN_LEVEL);
        trig[1] = wr_en && ((widx == IDX_COMMON_LEVEL) || (widx == IDX_LPGA_RCOM) ||
            (widx == IDX_LDAC_RCOM) || (widx == IDX_RPGA_RCOM) || (widx == IDX_RDAC_RCOM));
    end

    for (genvar p = 0; p < 2; p++) begin : g_pend
        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                pend_ff[p] <= 1'b1;
                cnt_ff[p] <= SETTLE_CNT;
            end else if (trig[p]) begin
                pend_ff[p] <= 1'b1;
                cnt_ff[p] <= SETTLE_CNT;
            end else if (cnt_ff[p] != '0) begin
                cnt_ff[p] <= cnt_ff[p] - 1'b1;
                pend_ff[p] <= (cnt_ff[p] != SETTLE_W'(1));
            end else begin
                pend_ff[p] <= 1'b0;
            end
        end
    end

    // ==========================================================================
    // Read channel: one read at a time, data registered
    always_comb begin
        rd_ok = addr_mapped(s_axi_araddr_i);
        case (addr_idx(s_axi_araddr_i))
            IDX_MAIN_LEVEL: rd_byte = {main_hp_ff.level, main_hp_ff.unmute,
                main_hp_ff.pd_hiz, pend_ff[0], main_hp_ff.power_up};
            IDX_COMMON_LEVEL: rd_byte = {common_hp_ff.level, common_hp_ff.unmute,
                common_hp_ff.pd_hiz, pend_ff[1], common_hp_ff.power_up};
            IDX_RSVD_66: rd_byte = rsvd66_ff;
            IDX_RSVD_69: rd_byte = rsvd69_ff;
            IDX_LPGA_RCOM: rd_byte = route_ff[0];
            IDX_LDAC_RCOM: rd_byte = route_ff[1];
            IDX_RPGA_RCOM: rd_byte = route_ff[2];
            IDX_RDAC_RCOM: rd_byte = route_ff[3];
            IDX_LPGA_LLINE: rd_byte = route_ff[4];
            IDX_RSVD_79: rd_byte = RSVD_79_VAL;
            default: rd_byte = RSVD_RO_VAL;
        endcase
        if (!rd_ok) begin
            rd_byte = 8'h00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rd_st_ff <= RMX_CH_IDLE;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= RESP_OKAY;
        end else begin
            case (rd_st_ff)
                RMX_CH_IDLE: begin
                    if (s_axi_arvalid_i && arready_ff) begin
                        rd_st_ff <= RMX_CH_RESP;
                        arready_ff <= 1'b0;
                        rvalid_ff <= 1'b1;
                        rdata_ff <= {24'h000000, rd_byte};
                        rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
                    end else begin
                        arready_ff <= 1'b1;
                    end
                end
                RMX_CH_RESP: begin
                    if (s_axi_rready_i) begin
                        rd_st_ff <= RMX_CH_IDLE;
                        rvalid_ff <= 1'b0;
                        arready_ff <= 1'b1;
                    end
                end
                default: begin
                    rd_st_ff <= RMX_CH_IDLE;
                    rvalid_ff <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================================
    // Port drive, all from flip-flops
    assign s_axi_awready_o = awready_ff;
    assign s_axi_wready_o = wready_ff;
    assign s_axi_bvalid_o = bvalid_ff;
    assign s_axi_bresp_o = bresp_ff;
    assign s_axi_arready_o = arready_ff;
    assign s_axi_rvalid_o = rvalid_ff;
    assign s_axi_rdata_o = rdata_ff;
    assign s_axi_rresp_o = rresp_ff;
    assign main_hp_o = main_hp_ff;
    assign common_hp_o = common_hp_ff;
    assign main_pend_o = pend_ff[0];
    assign common_pend_o = pend_ff[1];

    // ==========================================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    localparam int CHK_SETTLE = SETTLE_CYC;

    sequence s_rd_taken(logic [6:0] i);
        s_axi_arvalid_i && arready_ff && rd_ok && addr_idx(s_axi_araddr_i) == i;
    endsequence

    sequence s_rd_answer(logic [7:0] v);
        rvalid_ff && rdata_ff == {24'h000000, v} && rresp_ff == RESP_OKAY;
    endsequence

    chk_main_level_wr: assert property (wr_en && widx == IDX_MAIN_LEVEL |=>
        main_hp_o.level == $past(wdata_ff[LVL_MSB:LVL_LSB]) &&
        main_hp_o.unmute == $past(wdata_ff[MUTE_BIT]) &&
        main_hp_o.pd_hiz == $past(wdata_ff[PDHIZ_BIT]) &&
        main_hp_o.power_up == $past(wdata_ff[PWR_BIT]))
        else $error("main level register write not applied");

    chk_common_level_wr: assert property (wr_en && widx == IDX_COMMON_LEVEL |=>
        common_hp_o.level == $past(wdata_ff[LVL_MSB:LVL_LSB]) &&
        common_hp_o.unmute == $past(wdata_ff[MUTE_BIT]) &&
        common_hp_o.pd_hiz == $past(wdata_ff[PDHIZ_BIT]) &&
        common_hp_o.power_up == $past(wdata_ff[PWR_BIT]))
        else $error("common level register write not applied");

    chk_reset_levels: assert property ($fell(reset_i) |->
        main_hp_o == HP_CTRL_RST && common_hp_o == HP_CTRL_RST && pend_ff == 2'b11)
        else $error("level controls wrong after reset");

    chk_main_pend_set: assert property (trig[0] |=> pend_ff[0] [*8])
        else $error("main pending status not held after write");

    chk_common_pend_clear: assert property (trig[1] |=>
        pend_ff[1] ##[1:CHK_SETTLE] (!pend_ff[1] || trig[1]))
        else $error("common pending status never cleared");

    chk_rsvd79_read: assert property (s_rd_taken(IDX_RSVD_79) |=>
        s_rd_answer(RSVD_79_VAL))
        else $error("reserved 79 read wrong value");

    chk_ro_write_ignored: assert property (wr_go && idx_read_only(widx) |=>
        bvalid_ff && bresp_ff == RESP_SLVERR)
        else $error("write to read-only word not refused");

    // Data is taken at the address edge; pending may fall on that very edge
    chk_main_readback: assert property (s_rd_taken(IDX_MAIN_LEVEL) |=>
        s_rd_answer($past({main_hp_ff.level, main_hp_ff.unmute, main_hp_ff.pd_hiz,
            pend_ff[0], main_hp_ff.power_up})))
        else $error("main level readback mismatch");

    chk_rvalid_hold: assert property (rvalid_ff && !s_axi_rready_i |=>
        rvalid_ff && $stable(rdata_ff))
        else $error("read data dropped before taken");

endmodule : rmx_regs

/* File: hdl/rmx_pkg.sv */
/*
 * Package for the right output mixer control register bank: register indices,
 * field positions, reset values, settle timing and the carrier types.
 * Assumes a 100 MHz register clock and AXI4-Lite word access (byte address is
 * four times the register index).
 */
package rmx_pkg;

    // ==========================================================================
    // Register indices (byte address = index * 4)
    localparam logic [6:0] IDX_MAIN_LEVEL = 7'h41;
    localparam logic [6:0] IDX_RSVD_66 = 7'h42;
    localparam logic [6:0] IDX_LPGA_RCOM = 7'h43;
    localparam logic [6:0] IDX_LDAC_RCOM = 7'h44;
    localparam logic [6:0] IDX_RSVD_69 = 7'h45;
    localparam logic [6:0] IDX_RPGA_RCOM = 7'h46;
    localparam logic [6:0] IDX_RDAC_RCOM = 7'h47;
    localparam logic [6:0] IDX_COMMON_LEVEL = 7'h48;
    localparam logic [6:0] IDX_RSVD_RO_FIRST = 7'h49;
    localparam logic [6:0] IDX_RSVD_RO_LAST = 7'h4e;
    localparam logic [6:0] IDX_RSVD_79 = 7'h4f;
    localparam logic [6:0] IDX_RSVD_80 = 7'h50;
    localparam logic [6:0] IDX_LPGA_LLINE = 7'h51;

    // ==========================================================================
    // Field positions of the level control registers
    localparam int LVL_MSB = 7;
    localparam int LVL_LSB = 4;
    localparam int MUTE_BIT = 3;
    localparam int PDHIZ_BIT = 2;
    localparam int PEND_BIT = 1;
    localparam int PWR_BIT = 0;

    // ==========================================================================
    // Reset values
    localparam logic [3:0] LVL_RST = 4'h0;
    localparam logic [7:0] RSVD_RW_RST = 8'h00;
    localparam logic [7:0] RSVD_RO_VAL = 8'h00;
    localparam logic [7:0] RSVD_79_VAL = 8'h02;
    localparam logic [7:0] ROUTE_RST = 8'h00;

    // ==========================================================================
    // Gain settle timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETTLE_TIME_NS = 1000;
    localparam int SETTLE_CYC = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_W = $clog2(SETTLE_CYC + 1);

    // ==========================================================================
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================================
    // Routing registers, in output port order
    localparam int NUM_ROUTE = 5;
    localparam logic [6:0] ROUTE_IDX [NUM_ROUTE] = '{IDX_LPGA_RCOM, IDX_LDAC_RCOM,
        IDX_RPGA_RCOM, IDX_RDAC_RCOM, IDX_LPGA_LLINE};

    // ==========================================================================
    // Carrier types
    typedef struct packed {
        logic [3:0] level;
        logic unmute;
        logic pd_hiz;
        logic power_up;
    } rmx_hp_ctrl_s;

    typedef struct packed {
        logic en;
        logic [6:0] vol;
    } rmx_route_s;

    typedef enum logic [1:0] {
        RMX_CH_IDLE = 2'b01,
        RMX_CH_RESP = 2'b10
    } rmx_chan_e;

    localparam rmx_hp_ctrl_s HP_CTRL_RST = '{level: LVL_RST, unmute: 1'b0,
        pd_hiz: 1'b1, power_up: 1'b0};

endpackage : rmx_pkg

/* File: testbench/tb_right_output_mixer_control_regs.sv */
/*
 * Self-checking bench for the right output mixer register bank.
 * Assumes rmx_pkg and rmx_regs are compiled first; drives the AXI4-Lite port.
 */
`timescale 1ns/1ps

module tb_right_output_mixer_control_regs
    import rmx_pkg::*;
;
    // =========================================================================
    // Stimulus and observed signals
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, main_pend, common_pend;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    rmx_hp_ctrl_s main_hp, common_hp;
    rmx_route_s route [NUM_ROUTE];
    int n_fail = 0;
    int n_checks = 0;

    // 100 MHz clock
    always #5 clk_i = ~clk_i;

    rmx_regs u_dut (.clk_i(clk_i), .reset_i(reset_i),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .main_hp_o(main_hp),
        .common_hp_o(common_hp), .route_o(route), .main_pend_o(main_pend),
        .common_pend_o(common_pend));

    // =========================================================================
    // Shared helpers
    task automatic test_done;
        if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // Hang guard: a wait that runs out ends the run as a failure
    task automatic give_up(input string what);
        n_fail++;
        $display("MISMATCH %0t timeout %s", $time, what);
        test_done();
    endtask : give_up

    // One write; address and data offered together, each released at its own take
    task automatic axi_wr(input logic [6:0] idx, input logic [7:0] d, input logic [3:0] st,
                          input logic [1:0] er);
        int n;
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        n = 0;
        awvalid <= 1'b1;
        awaddr <= {23'h0, idx, 2'b00};
        wvalid <= 1'b1;
        wdata <= {24'h0, d};
        wstrb <= st;
        while (!(aw_done && w_done)) begin
            @(posedge clk_i);
            if (!aw_done && awready === 1'b1) begin
                awvalid <= 1'b0;
                aw_done = 1'b1;
            end
            if (!w_done && wready === 1'b1) begin
                wvalid <= 1'b0;
                w_done = 1'b1;
            end
            if (++n > 50) give_up("write take");
        end
        bready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (++n > 100) give_up("write answer");
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er}, "bresp");
    endtask : axi_wr

    // One read; checks data and response code
    task automatic axi_rd(input logic [6:0] idx, input logic [7:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        arvalid <= 1'b1;
        araddr <= {23'h0, idx, 2'b00};
        do begin
            @(posedge clk_i);
            if (++n > 50) give_up("read take");
        end while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (++n > 100) give_up("read answer");
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, {24'h0, ed}, "rdata");
        chk({30'h0, rresp}, {30'h0, er}, "rresp");
    endtask : axi_rd

    // Count cycles until a pending flag falls; settle is 100 cycles
    task automatic wait_settle(input logic main_sel, output int n);
        n = 0;
        while ((main_sel ? main_pend : common_pend) !== 1'b0) begin
            @(posedge clk_i);
            if (++n > 300) give_up("settle");
        end
    endtask : wait_settle

    // =========================================================================
    // Scenarios
    task automatic sc_reset_values;
        int i;
        logic [7:0] e;
        chk({31'h0, main_pend}, 32'h1, "main pend at reset");
        chk({31'h0, common_pend}, 32'h1, "common pend at reset");
        chk({25'h0, main_hp}, {25'h0, HP_CTRL_RST}, "main ctrl reset");
        chk({25'h0, common_hp}, {25'h0, HP_CTRL_RST}, "common ctrl reset");
        for (i = 'h41; i <= 'h51; i++) begin
            e = (i == 'h41 || i == 'h48) ? 8'h06 : (i == 'h4f) ? 8'h02 : 8'h00;
            axi_rd(i[6:0], e, RESP_OKAY);
        end
    endtask : sc_reset_values

    // Main level: full setting applied at once, pending while settling, then cleared
    task automatic sc_main_level;
        int n;
        wait_settle(1'b1, n);
        wait_settle(1'b0, n);
        axi_wr(IDX_MAIN_LEVEL, 8'h9d, 4'h1, RESP_OKAY);
        chk({25'h0, main_hp}, {25'h0, 4'h9, 3'b111}, "main ctrl");
        chk({31'h0, common_pend}, 32'h0, "common untouched");
        axi_rd(IDX_MAIN_LEVEL, 8'h9f, RESP_OKAY);
        wait_settle(1'b1, n);
        // Write answer edge and the read that follows use up two settle cycles
        chk(n, SETTLE_CYC - 2, "main settle cycles");
        axi_rd(IDX_MAIN_LEVEL, 8'h9d, RESP_OKAY);
        axi_wr(IDX_MAIN_LEVEL, 8'h00, 4'h1, RESP_OKAY);
        chk({25'h0, main_hp}, 32'h0, "main muted weak drive");
    endtask : sc_main_level

    // Common level with the opposite bit pattern
    task automatic sc_common_level;
        int n;
        axi_wr(IDX_COMMON_LEVEL, 8'h58, 4'h1, RESP_OKAY);
        chk({25'h0, common_hp}, {25'h0, 4'h5, 3'b100}, "common ctrl");
        axi_rd(IDX_COMMON_LEVEL, 8'h5a, RESP_OKAY);
        wait_settle(1'b0, n);
        axi_wr(IDX_COMMON_LEVEL, 8'h97, 4'h1, RESP_OKAY);
        chk({25'h0, common_hp}, {25'h0, 4'h9, 3'b011}, "common ctrl 2");
        wait_settle(1'b0, n);
        axi_rd(IDX_COMMON_LEVEL, 8'h95, RESP_OKAY);
    endtask : sc_common_level

    // Every routing register, boundary codes of enable and volume
    task automatic sc_routes;
        logic [7:0] v [NUM_ROUTE];
        int k;
        v = '{8'hff, 8'h01, 8'h7f, 8'h80, 8'hc4};
        for (k = 0; k < NUM_ROUTE; k++) begin
            axi_wr(ROUTE_IDX[k], v[k], 4'h1, RESP_OKAY);
            chk({24'h0, route[k]}, {24'h0, v[k]}, "route out");
        end
        for (k = 0; k < NUM_ROUTE; k++) axi_rd(ROUTE_IDX[k], v[k], RESP_OKAY);
        chk({31'h0, common_pend}, 32'h1, "route write restarts");
    endtask : sc_routes

    // Read-only, unmapped and strobe-less accesses leave state alone
    task automatic sc_refusals;
        axi_wr(IDX_RSVD_79, 8'h55, 4'h1, RESP_SLVERR);
        axi_rd(IDX_RSVD_79, RSVD_79_VAL, RESP_OKAY);
        axi_wr(IDX_RSVD_RO_LAST, 8'hff, 4'h1, RESP_SLVERR);
        axi_rd(IDX_RSVD_RO_LAST, RSVD_RO_VAL, RESP_OKAY);
        axi_rd(7'h52, 8'h00, RESP_SLVERR);
        axi_wr(IDX_LPGA_LLINE, 8'h00, 4'h0, RESP_OKAY);
        axi_rd(IDX_LPGA_LLINE, 8'hc4, RESP_OKAY);
    endtask : sc_refusals

    // =========================================================================
    // Main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        sc_reset_values();
        sc_main_level();
        sc_common_level();
        sc_routes();
        sc_refusals();
        test_done();
    end

endmodule : tb_right_output_mixer_control_regs
